// ===== mem_seq_pkg.sv
// package: sizes, field layouts, reset values and op codes for the memory sequencer
package mem_seq_pkg;
    // program memory
    localparam int          ROM_WORD_W   = 8;
    localparam int          PC_W         = 11;
    localparam int          ROM_DEPTH    = 2048;
    localparam logic [10:0] PC_RST       = 11'h000;
    localparam logic [10:0] PC_MAX       = 11'h7ff;
    localparam logic [10:0] PC_ONE       = 11'h001;
    localparam int          PAGE_BITS    = 6;
    localparam int          BLOCK_BITS   = 8;
    localparam int          CHAPTER_BITS = 11;
    // data memory
    localparam int          DIGIT_W      = 4;
    localparam int          COL_W        = 4;
    localparam int          ROW_W        = 4;
    localparam int          ROWS         = 10;
    localparam int          COLS         = 16;
    localparam int          DMEM_DEPTH   = 160;
    localparam int          DADDR_W      = 8;
    localparam logic [3:0]  ROW_RST      = 4'h0;
    localparam logic [3:0]  COL_RST      = 4'h0;
    localparam logic [3:0]  DIGIT_RST    = 4'h0;
    localparam logic [3:0]  ROW_LIMIT    = 4'h9;
    // program counter operations
    typedef enum logic [3:0] {
        PC_STEP     = 4'h1,
        PC_JUMP     = 4'h2,
        PC_PAGEJUMP = 4'h4,
        PC_BLOCKIND = 4'h8
    } pc_op_t;
    // data path operations
    typedef enum logic [6:0] {
        D_NONE     = 7'h01,
        D_LOADADDR = 7'h02,
        D_ACCADDR  = 7'h04,
        D_READ     = 7'h08,
        D_WRITE    = 7'h10,
        D_DIRLOAD  = 7'h20,
        D_DIRXCHG  = 7'h40
    } d_op_t;
endpackage

// ===== digit_mem.sv
// digit memory: row-by-column matrix of 4-bit digits in flip-flops
`timescale 1ns/100ps
module digit_mem (
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             resetn,
    // access
    input  wire logic [mem_seq_pkg::DADDR_W-1:0]  addr,
    input  wire logic                             wr_en,
    input  wire logic [mem_seq_pkg::DIGIT_W-1:0]  wr_data,
    output logic      [mem_seq_pkg::DIGIT_W-1:0]  rd_data,
    output logic                                  addr_ok
);
    import mem_seq_pkg::*;

    logic [DIGIT_W-1:0] mem_r [DMEM_DEPTH];
    logic [7:0]         idx;

    // rows past the configured count are unimplemented
    assign addr_ok = (addr[DADDR_W-1:COL_W] <= ROW_LIMIT);
    assign idx     = addr;
    assign rd_data = addr_ok ? mem_r[idx] : DIGIT_RST;

    // writes to unimplemented rows are dropped
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < DMEM_DEPTH; i++) begin
                mem_r[i] <= DIGIT_RST;
            end
        end else if (wr_en && addr_ok) begin
            mem_r[idx] <= wr_data;
        end
    end
endmodule // digit_mem

// ===== mem_seq.sv
// memory sequencer: program counter, digit address register, data path
`timescale 1ns/100ps
// Notes on behaviour
// - program store holds eight-bit words, one fetched per counter value.
// - counter width covers 512, 1024 or 2048 words.
// - counter is zero after reset, steps by one, wraps at top.
// - counter value is driven out on pins for external program store.
// - a page is 64 aligned words, low six bits span it.
// - a block is 256 aligned words; used only by lookup and indirect jump.
// - a chapter spans the low 11 bits; only matters above 2048 words.
// - stepping carries freely across page, block and chapter edges.
// - only some jumps and calls are confined by page or chapter.
// - data store is rows by 4-bit columns; one digit per access.
// - data geometry is 4x8, 4x16, 8x16 or 10x16.
// - data store addressed by its own address register, or by direct_addr for direct forms.
// - address register loads from operand or from accumulator.
// - column field is 4 bits, row field 4 bits.
// - on command the column field is copied to the latched digit output.
// - selected digit is read and written through the accumulator.
// - direct load and exchange use their own address, register untouched.
// - digit output holds until next write; sourced only from column field.
// - accumulator is 4 bits wide.
module mem_seq #(
    parameter int ROM_WORDS = mem_seq_pkg::ROM_DEPTH
) (
    // clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    // program counter control
    input  wire logic                                  fetch,
    input  wire mem_seq_pkg::pc_op_t                   pc_op,
    input  wire logic [mem_seq_pkg::PC_W-1:0]          pc_target,
    input  wire logic [mem_seq_pkg::BLOCK_BITS-1:0]    pc_low,
    // instruction word from program store
    input  wire logic [mem_seq_pkg::ROM_WORD_W-1:0]    rom_data,
    // data path control
    input  wire mem_seq_pkg::d_op_t                    d_op,
    input  wire logic [mem_seq_pkg::ROW_W-1:0]         row_operand,
    input  wire logic [mem_seq_pkg::COL_W-1:0]         col_operand,
    input  wire logic [mem_seq_pkg::DADDR_W-1:0]       direct_addr,
    input  wire logic [mem_seq_pkg::DIGIT_W-1:0]       acc_in,
    input  wire logic                                  digit_out_wr,
    // program address pins and fetched word
    output logic      [mem_seq_pkg::PC_W-1:0]          pc_pins,
    output logic      [mem_seq_pkg::ROM_WORD_W-1:0]    instr_r,
    // data path results
    output logic      [mem_seq_pkg::DIGIT_W-1:0]       acc_out,
    output logic                                       acc_load,
    output logic      [mem_seq_pkg::ROW_W-1:0]         row_select_field,
    output logic      [mem_seq_pkg::COL_W-1:0]         digit_select_field,
    output logic      [mem_seq_pkg::DIGIT_W-1:0]       digit_out
);
    import mem_seq_pkg::*;

    localparam logic [PC_W-1:0] TOP_ADDR = PC_W'(ROM_WORDS - 1);

    logic [PC_W-1:0]       pc_r;
    logic [PC_W-1:0]       pc_nxt;
    logic [ROW_W-1:0]      row_r;
    logic [COL_W-1:0]      col_r;
    logic [DIGIT_W-1:0]    dout_r;
    logic [DIGIT_W-1:0]    acc_r;
    logic                  accld_r;
    logic [ROM_WORD_W-1:0] instr_q;
    logic [DADDR_W-1:0]    mem_addr;
    logic                  mem_wr;
    logic [DIGIT_W-1:0]    mem_rd;
    logic                  mem_ok;
    logic                  direct;

    // next counter value; page and block jumps keep the upper bits
    always_comb begin
        pc_nxt = pc_r;
        case (pc_op)
            PC_STEP: begin
                // plain binary step, carries across every boundary
                pc_nxt = (pc_r == TOP_ADDR) ? PC_RST : pc_r + PC_ONE;
            end
            PC_JUMP: begin
                // long forms may reach anywhere inside the chapter
                pc_nxt = pc_target;
            end
            PC_PAGEJUMP: begin
                // short forms stay within the current page
                pc_nxt = {pc_r[PC_W-1:PAGE_BITS],
                          pc_target[PAGE_BITS-1:0]};
            end
            PC_BLOCKIND: begin
                // lookup and indirect jump replace the low byte only
                pc_nxt = {pc_r[PC_W-1:BLOCK_BITS], pc_low};
            end
            default: begin
                pc_nxt = pc_r;
            end
        endcase
    end

    // program counter; moves only when a word is fetched
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pc_r <= PC_RST;
        end else if (fetch) begin
            pc_r <= pc_nxt & TOP_ADDR;
        end
    end

    // fetched word capture: one eight-bit word per address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            instr_q <= 8'h00;
        end else if (fetch) begin
            instr_q <= rom_data;
        end
    end

    assign pc_pins = pc_r;
    assign instr_r = instr_q;

    // direct forms bring their own address and leave the register alone
    assign direct   = (d_op == D_DIRLOAD) || (d_op == D_DIRXCHG);
    assign mem_addr = direct ? direct_addr : {row_r, col_r};
    assign mem_wr   = (d_op == D_WRITE) || (d_op == D_DIRXCHG);

    digit_mem u_mem (
        .clk     (clk),
        .resetn  (resetn),
        .addr    (mem_addr),
        .wr_en   (mem_wr),
        .wr_data (acc_in),
        .rd_data (mem_rd),
        .addr_ok (mem_ok)
    );

    // address register: operand or accumulator load
    always_ff @(posedge clk) begin
        if (!resetn) begin
            row_r <= ROW_RST;
            col_r <= COL_RST;
        end else begin
            case (d_op)
                D_LOADADDR: begin
                    row_r <= row_operand;
                    col_r <= col_operand;
                end
                D_ACCADDR: begin
                    // only the column comes from the accumulator
                    col_r <= acc_in;
                end
                default: begin
                    row_r <= row_r;
                end
            endcase
        end
    end

    assign row_select_field   = row_r;
    assign digit_select_field = col_r;

    // accumulator return path; 4 bits, one-cycle load strobe
    // the digit is taken only on a read, direct load or direct exchange, so the value
    // stands until the next such access instead of following whatever the address register shows
    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_r   <= DIGIT_RST;
            accld_r <= 1'b0;
        end else begin
            accld_r <= (d_op == D_READ) || direct;
            if ((d_op == D_READ) || direct) begin
                acc_r <= mem_rd;
            end
        end
    end

    assign acc_out  = acc_r;
    assign acc_load = accld_r;

    // digit output latch holds until written, only from the column field
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dout_r <= DIGIT_RST;
        end else if (digit_out_wr) begin
            dout_r <= col_r;
        end
    end

    assign digit_out = dout_r;

    // geometry: row field 4 bits covers up to 10 rows of 16 digits
    // smaller variants just leave high rows unused

    // checks
    a_pc_reset: assert property (@(posedge clk)
        !resetn |=> pc_r == PC_RST)
        else $error("counter not zero after reset");
    a_pc_step: assert property (@(posedge clk) disable iff (!resetn)
        fetch && pc_op == PC_STEP && pc_r != TOP_ADDR |=>
        pc_r == $past(pc_r) + PC_ONE)
        else $error("counter step wrong");
    a_pc_wrap: assert property (@(posedge clk) disable iff (!resetn)
        fetch && pc_op == PC_STEP && pc_r == TOP_ADDR |=> pc_r == PC_RST)
        else $error("counter did not wrap");
    a_page_keep: assert property (@(posedge clk) disable iff (!resetn)
        fetch && pc_op == PC_PAGEJUMP |=>
        pc_r[PC_W-1:PAGE_BITS] == $past(pc_r[PC_W-1:PAGE_BITS]))
        else $error("page jump left page");
    a_block_keep: assert property (@(posedge clk) disable iff (!resetn)
        fetch && pc_op == PC_BLOCKIND |=>
        pc_r[PC_W-1:BLOCK_BITS] == $past(pc_r[PC_W-1:BLOCK_BITS]))
        else $error("block lookup left block");
    a_pc_hold: assert property (@(posedge clk) disable iff (!resetn)
        !fetch |=> $stable(pc_r))
        else $error("counter moved without fetch");
    a_direct_keep: assert property (@(posedge clk) disable iff (!resetn)
        direct |=> $stable(row_r) && $stable(col_r))
        else $error("direct op changed address");
    a_dout_load: assert property (@(posedge clk) disable iff (!resetn)
        digit_out_wr |=> digit_out == $past(col_r))
        else $error("digit output not loaded");
    a_dout_hold: assert property (@(posedge clk) disable iff (!resetn)
        !digit_out_wr |=> $stable(digit_out))
        else $error("digit output changed");
    a_addr_load: assert property (@(posedge clk) disable iff (!resetn)
        d_op == D_LOADADDR |=> row_r == $past(row_operand)
        && col_r == $past(col_operand))
        else $error("address load wrong");
    a_acc_read: assert property (@(posedge clk) disable iff (!resetn)
        d_op == D_READ |=> acc_load && acc_out == $past(mem_rd))
        else $error("read did not reach accumulator");
    a_acc_hold: assert property (@(posedge clk) disable iff (!resetn)
        !(d_op == D_READ || direct) |=> $stable(acc_out) && !acc_load)
        else $error("accumulator changed without a read");
    a_pins_pc: assert property (@(posedge clk) disable iff (!resetn)
        fetch && pc_op == PC_JUMP |=> pc_pins == ($past(pc_target) & TOP_ADDR))
        else $error("pins do not show jump target");

    c_wrap: cover property (@(posedge clk) disable iff (!resetn)
        fetch && pc_op == PC_STEP && pc_r == TOP_ADDR);
    c_xchg: cover property (@(posedge clk) disable iff (!resetn)
        d_op == D_DIRXCHG && mem_ok);
    c_dout: cover property (@(posedge clk) disable iff (!resetn)
        d_op == D_LOADADDR ##1 digit_out_wr);
    c_bad_row: cover property (@(posedge clk) disable iff (!resetn)
        d_op == D_READ && !mem_ok);
endmodule // mem_seq

// ===== rom_model.sv
// external program store model answering the counter pins
`timescale 1ns/100ps
module rom_model (
    // program address pins
    input  wire logic [mem_seq_pkg::PC_W-1:0]       addr,
    // instruction word back to the core
    output logic      [mem_seq_pkg::ROM_WORD_W-1:0] data
);
    import mem_seq_pkg::*;
    // read-only eight-bit word per address, answered at once; the upper
    // bits are folded in so a stuck high counter bit changes the word
    assign data = addr[7:0] ^ {5'h00, addr[10:8]};
endmodule // rom_model

// ===== tb_top.sv
// self-checking bench for the memory sequencer with its program store
`timescale 1ns/100ps
module tb_top;
    import mem_seq_pkg::*;
    logic                  clk, resetn, fetch, digit_out_wr, acc_load;
    pc_op_t                pc_op;
    d_op_t                 d_op;
    logic [PC_W-1:0]       pc_target, pc_pins;
    logic [BLOCK_BITS-1:0] pc_low;
    logic [ROM_WORD_W-1:0] rom_data, instr_r;
    logic [ROW_W-1:0]      row_operand, row_select_field;
    logic [COL_W-1:0]      col_operand, digit_select_field;
    logic [DADDR_W-1:0]    direct_addr;
    logic [DIGIT_W-1:0]    acc_in, acc_out, digit_out;
    int                    miscompares, cmp_count;
    logic [10:0]           tgt [3] = '{11'h03f, 11'h0ff, 11'h7ff};
    logic [10:0]           nxt [3] = '{11'h040, 11'h100, 11'h000};

    mem_seq mem_seq_i (.clk(clk), .resetn(resetn), .fetch(fetch),
        .pc_op(pc_op), .pc_target(pc_target), .pc_low(pc_low),
        .rom_data(rom_data), .d_op(d_op), .row_operand(row_operand),
        .col_operand(col_operand), .direct_addr(direct_addr),
        .acc_in(acc_in), .digit_out_wr(digit_out_wr), .pc_pins(pc_pins),
        .instr_r(instr_r), .acc_out(acc_out), .acc_load(acc_load),
        .row_select_field(row_select_field),
        .digit_select_field(digit_select_field), .digit_out(digit_out));
    rom_model rom_model_i (.addr(pc_pins), .data(rom_data));

    // free-running core clock
    always #5 clk = ~clk;

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one counter request, taken at the second edge, settled after it
    task automatic pc_do(pc_op_t op, logic [10:0] t, logic [7:0] low);
        @(posedge clk);
        fetch     <= 1'b1;
        pc_op     <= op;
        pc_target <= t;
        pc_low    <= low;
        @(posedge clk);
        fetch     <= 1'b0;
        #1;
    endtask

    // one data path request; dw also latches the column field
    task automatic d_do(d_op_t op, logic [3:0] r, logic [3:0] c,
                        logic [7:0] da, logic [3:0] acc, logic dw);
        @(posedge clk);
        d_op         <= op;
        row_operand  <= r;
        col_operand  <= c;
        direct_addr  <= da;
        acc_in       <= acc;
        digit_out_wr <= dw;
        @(posedge clk);
        d_op         <= D_NONE;
        digit_out_wr <= 1'b0;
        #1;
    endtask

    task automatic t_reset;
        chk(pc_pins, 16'h0000);
        chk({instr_r, acc_out, 3'h0, acc_load}, 16'h0000);
        chk({row_select_field, digit_select_field, digit_out}, 16'h0000);
    endtask

    // back-to-back steps: three fetches from zero
    task automatic t_step;
        @(posedge clk);
        fetch <= 1'b1;
        pc_op <= PC_STEP;
        repeat (3) @(posedge clk);
        fetch <= 1'b0;
        #1;
        chk(pc_pins, 16'h0003);
        chk(instr_r, 16'h0002);
    endtask

    // stepping over page, block and top edges is never held back
    task automatic t_bound;
        for (int i = 0; i < 3; i++) begin
            pc_do(PC_JUMP, tgt[i], 8'h00);
            chk(pc_pins, {5'h00, tgt[i]});
            pc_do(PC_STEP, 11'h000, 8'h00);
            chk(pc_pins, {5'h00, nxt[i]});
            chk(instr_r, {8'h00, tgt[i][7:0] ^ {5'h00, tgt[i][10:8]}});
        end
    endtask

    // page jump keeps the page, block jump keeps the block
    task automatic t_seg;
        pc_do(PC_JUMP, 11'h1c7, 8'h00);
        pc_do(PC_PAGEJUMP, 11'h015, 8'h00);
        chk(pc_pins, 16'h01d5);
        pc_do(PC_BLOCKIND, 11'h000, 8'h2b);
        chk(pc_pins, 16'h012b);
    endtask

    task automatic t_data;
        d_do(D_LOADADDR, 4'h2, 4'h5, 8'h00, 4'h0, 1'b0);
        chk({row_select_field, digit_select_field}, 16'h0025);
        d_do(D_WRITE, 4'h0, 4'h0, 8'h00, 4'ha, 1'b0);
        d_do(D_READ, 4'h0, 4'h0, 8'h00, 4'h0, 1'b0);
        chk({acc_load, acc_out}, 16'h001a);
        d_do(D_DIRXCHG, 4'h0, 4'h0, 8'h25, 4'h3, 1'b0);
        chk(acc_out, 16'h000a);
        chk({row_select_field, digit_select_field}, 16'h0025);
        d_do(D_DIRLOAD, 4'h0, 4'h0, 8'h25, 4'h0, 1'b0);
        chk(acc_out, 16'h0003);
        d_do(D_ACCADDR, 4'h0, 4'h0, 8'h00, 4'h7, 1'b1);
        chk({row_select_field, digit_select_field}, 16'h0027);
        d_do(D_NONE, 4'h0, 4'h0, 8'h00, 4'h0, 1'b1);
        chk(digit_out, 16'h0007);
        d_do(D_LOADADDR, 4'h9, 4'h1, 8'h00, 4'h0, 1'b0);
        chk(digit_out, 16'h0007);
        d_do(D_WRITE, 4'h0, 4'h0, 8'h00, 4'hc, 1'b0);
        // row ten is past the top: write dropped, read back as zero
        d_do(D_LOADADDR, 4'ha, 4'h1, 8'h00, 4'h0, 1'b0);
        d_do(D_WRITE, 4'h0, 4'h0, 8'h00, 4'h5, 1'b0);
        d_do(D_READ, 4'h0, 4'h0, 8'h00, 4'h0, 1'b0);
        chk(acc_out, 16'h0000);
        d_do(D_LOADADDR, 4'h9, 4'h1, 8'h00, 4'h0, 1'b0);
        d_do(D_READ, 4'h0, 4'h0, 8'h00, 4'h0, 1'b0);
        chk(acc_out, 16'h000c);
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        clk = 1'b0; resetn = 1'b0; fetch = 1'b0; pc_op = PC_STEP;
        pc_target = 11'h000; pc_low = 8'h00; d_op = D_NONE;
        row_operand = 4'h0; col_operand = 4'h0; direct_addr = 8'h00;
        acc_in = 4'h0; digit_out_wr = 1'b0;
        miscompares = 0; cmp_count = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1;
        t_reset();
        t_step();
        t_bound();
        t_seg();
        t_data();
        close_out();
    end
endmodule // tb_top
